// ### dv/reset_pin_model.sv
// External circuitry on the bidirectional reset pin, with pull-up
`timescale 1ns/1ps
module reset_pin_model (
    input  wire logic drive_in,  // Device drive value
    input  wire logic oe_in,     // Device drive enable
    input  wire logic hold_in,   // Hold the pin low from outside
    output logic      pin_out    // Resolved pin level
);
    // Pull-up sets the level when nobody drives
    assign pin_out = oe_in ? drive_in : (hold_in ? 1'b0 : 1'b1);
endmodule : reset_pin_model

// ### dv/testbench.sv
// Self-checking testbench of the reset sequencer and trim registers
`timescale 1ns/1ps
`include "rst_seq_cfg.svh"
module testbench;
    import rst_seq_pkg::*;
    logic               clk, rst_n, pin, oe, drv, ill, wdog, osc, lock, stop, cfg;
    logic               bus_wr, bus_rd, ires, irq, hold, rd_d;
    logic [`TRIM_W-1:0] flash, trim;
    logic [`ADDR_W-1:0] addr;
    logic [`DATA_W-1:0] wdata, rdata;
    logic [1:0]         vec;
    logic [`DATA_W-1:0] expq [$];
    vector_t            exp_vec [3] = '{VEC_POR, VEC_WDOG, VEC_OSC};
    int                 fails, n_checks, seed, oe_cnt, int_cnt, k;
    logic [15:0]        v;

    reset_sequencer_and_ref_trim u_dut (
        .CLK_IN(clk), .RST_N_IN(rst_n), .RESET_PIN_IN(pin), .RESET_PIN_OUT(drv),
        .RESET_PIN_OE_OUT(oe), .ILLEGAL_ACCESS_IN(ill), .WATCHDOG_TIMEOUT_IN(wdog),
        .OSC_FAIL_IN(osc), .FREQ_LOCK_IN(lock), .STOP_ENTRY_IN(stop),
        .LOOP_CFG_WRITE_IN(cfg), .FLASH_TRIM_IN(flash), .ADDR_IN(addr), .WDATA_IN(wdata),
        .WR_IN(bus_wr), .RD_IN(bus_rd), .RDATA_OUT(rdata), .TRIM_OUT(trim),
        .INTERNAL_RESET_OUT(ires), .VECTOR_OUT(vec), .LOCK_IRQ_OUT(irq));
    reset_pin_model u_pin (.drive_in(drv), .oe_in(oe), .hold_in(hold), .pin_out(pin));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ----------------------------------------
    // Read monitor: oldest note against data
    // ----------------------------------------
    always @(posedge clk) rd_d <= bus_rd;
    always @(negedge clk) begin
        if (rd_d === 1'b1) begin
            check(expq.size() > 0 && rdata === expq[0], "read data");
            void'(expq.pop_front());
        end
    end

    task automatic check(input logic ok, input string msg);
        n_checks++;
        if (ok !== 1'b1) begin
            fails++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask : check

    task automatic conclude;
        $display("checks %0d, fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : conclude

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_wr <= 1'b1;
        addr   <= a;
        wdata  <= d;
        @(posedge clk);
        bus_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        expq.push_back(e);
        @(posedge clk);
        bus_rd <= 1'b1;
        addr   <= a;
        @(posedge clk);
        bus_rd <= 1'b0;
    endtask : rd

    task automatic ev(input int n);
        @(posedge clk);
        {ill, wdog, osc} <= 3'b100 >> n;
        @(posedge clk);
        {ill, wdog, osc} <= 3'b000;
    endtask : ev

    task automatic run_seq;
        int i;
        oe_cnt  = 0;
        int_cnt = 0;
        for (i = 0; i < 40 && oe !== 1'b1; i++) @(negedge clk);
        while (ires === 1'b1 && int_cnt < 5000) begin
            oe_cnt += (oe === 1'b1);
            int_cnt++;
            @(negedge clk);
        end
        if (int_cnt == 0 || int_cnt >= 5000) begin
            check(1'b0, "sequence wait ran out");
            conclude();
        end
    endtask : run_seq

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {rst_n, ill, wdog, osc, lock, stop, cfg, bus_wr, bus_rd, hold} = '0;
        addr  = '0;
        wdata = '0;
        seed  = 66;
        flash = $random(seed);
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        run_seq();
        check(oe_cnt inside {[516:517]}, "power-on drive length");
        repeat (2) @(negedge clk);
        check(trim === flash, "trim load");
        rd(`OFS_TRIM_HI, {7'h00, flash[8]});
        rd(`OFS_TRIM_LO, flash[7:0]);
        rd(`OFS_FLAGS, 8'h40);
        for (k = 0; k < 3; k++) begin
            v = $random(seed);
            wr(`OFS_TRIM_HI, v[15:8]);
            wr(`OFS_TRIM_LO, v[7:0]);
            rd(`OFS_TRIM_HI, {7'h00, v[8]});
            rd(`OFS_TRIM_LO, v[7:0]);
            check(trim === v[8:0], "trim output");
        end
        wr(`OFS_TEST_ZERO, 8'hFF);
        rd(`OFS_TEST_ZERO, 8'h00);
        wr(`OFS_TEST_ONE, 8'h00);
        rd(`OFS_TEST_ONE, `TEST_ONE_VALUE);
        rd(8'h7F, 8'h00);
        wr(`OFS_FLAGS, 8'h40);
        rd(`OFS_FLAGS, 8'h00);
        for (k = 0; k < 3; k++) begin
            wr(`OFS_CTRL, 8'h80);
            lock <= 1'b1;
            repeat (4) @(posedge clk);
            rd(`OFS_FLAGS, 8'h18);
            check(irq === 1'b1, "lock request");
            wr(`OFS_FLAGS, 8'h10);
            rd(`OFS_FLAGS, 8'h08);
            check(irq === 1'b0, "lock request cleared");
            @(posedge clk);
            lock <= 1'b0;
            case (k)
                0: {bus_wr, addr, wdata} <= {1'b1, `OFS_TRIM_LO, 8'h33};
                1: stop <= 1'b1;
                default: cfg <= 1'b1;
            endcase
            @(posedge clk);
            {bus_wr, stop, cfg} <= 3'b000;
            rd(`OFS_FLAGS, 8'h00);
        end
        for (k = 0; k < 3; k++) begin
            @(posedge clk);
            flash <= $random(seed);
            if (k == 2) begin
                ev(2);
                repeat (20) @(negedge clk);
                check(oe === 1'b0, "gated monitor failure");
                wr(`OFS_CTRL, 8'h40);
            end
            ev(k);
            run_seq();
            check(oe_cnt inside {[516:517]}, "drive length");
            check(int_cnt inside {[772:774]}, "sequence length");
            check(vec === exp_vec[k], "vector");
            repeat (2) @(negedge clk);
            check(trim === flash, "trim reload");
            rd(`OFS_FLAGS, (k == 0) ? 8'h04 : 8'h00);
            wr(`OFS_FLAGS, 8'h04);
        end
        fork
            begin
                hold <= 1'b1;
                repeat (1500) @(posedge clk);
                hold <= 1'b0;
            end
            run_seq();
        join
        check(int_cnt > 1400, "held reset length");
        check(vec === VEC_POR, "pin vector");
        fork
            begin
                ev(1);
                repeat (100) @(posedge clk);
                ev(0);
            end
            run_seq();
        join
        check(oe_cnt inside {[600:630]}, "restarted drive");
        check(vec === VEC_WDOG, "restart vector");
        // Second power-on in mid-run: flags back to power-on state
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        run_seq();
        check(oe_cnt inside {[516:517]}, "second power-on drive");
        repeat (2) @(negedge clk);
        check(trim === flash, "trim after power-on");
        rd(`OFS_FLAGS, 8'h40);
        repeat (4) @(negedge clk);
        conclude();
    end
endmodule : testbench

// ### include/rst_seq_cfg.svh
// Offsets, field positions, reset values and sequence counts of the reset sequencer
`ifndef RST_SEQ_CFG_SVH
`define RST_SEQ_CFG_SVH

`define ADDR_W           8
`define DATA_W           8
`define TRIM_W           9
`define CNT_W            10
`define SYNC_W           2

// Register offsets
`define OFS_CTRL         8'h36
`define OFS_FLAGS        8'h37
`define OFS_TRIM_HI      8'h38
`define OFS_TRIM_LO      8'h39
`define OFS_TEST_ZERO    8'h3A
`define OFS_TEST_ONE     8'h3B

// Field positions
`define BIT_LOCK_IE      7
`define BIT_OSC_EN       6
`define BIT_POR          6
`define BIT_LOCK_IF      4
`define BIT_LOCK_ST      3
`define BIT_ILLEGAL      2
`define BIT_TRIM_TOP     0

// Reset values
`define RST_BYTE         8'h00
`define RST_TRIM         9'h000
`define RST_CNT          10'h000
// Synchroniser reset level: pin released, monitor failure absent
`define SYNC_IDLE        2'h1
// Arbitrary contents returned by the undefined test register
`define TEST_ONE_VALUE   8'h5A

// Sequence lengths in clock cycles: 516 driven low, then 256 before sampling
`define DRIVE_CYCLES     10'h204
`define SAMPLE_WAIT      10'h100
`define CNT_STEP         10'h001

`endif

// ### include/rst_seq_pkg.sv
// Types of the reset sequencer and reference trim block
package rst_seq_pkg;
`include "rst_seq_cfg.svh"

    typedef enum logic [3:0] {
        S_IDLE  = 4'h1,
        S_DRIVE = 4'h2,
        S_WAIT  = 4'h4,
        S_HOLD  = 4'h8
    } seq_state_t;

    typedef enum logic [1:0] {
        VEC_POR  = 2'h0,
        VEC_OSC  = 2'h1,
        VEC_WDOG = 2'h2
    } vector_t;

    typedef struct packed {
        seq_state_t              state;
        logic [`CNT_W-1:0]       cnt;
        logic                    osc_pend;
        logic                    wdog_pend;
        vector_t                 vector;
        logic                    lock_irq_enable;
        logic                    osc_enable;
        logic                    freq_lock_status;
        logic                    lock_change_flag;
        logic                    power_on_flag;
        logic                    illegal_access_flag;
        logic [`DATA_W-1:0]      rdata;
    } top_state_t;

    typedef struct packed {
        logic [`TRIM_W-1:0]      trim;
        logic                    sys_reset_q;
    } trim_state_t;

    typedef struct packed {
        logic [`SYNC_W-1:0]      meta;
        logic [`SYNC_W-1:0]      stable;
    } sync_state_t;

endpackage : rst_seq_pkg

// ### include/trim_if.sv
// Carrier between the sequencer top and the trim register file
`timescale 1ns/1ps
`include "rst_seq_cfg.svh"
interface trim_if;
    logic [`ADDR_W-1:0] addr;
    logic [`DATA_W-1:0] wdata;
    logic               wr;
    logic               sys_reset;
    logic [`TRIM_W-1:0] flash_trim;
    logic [`TRIM_W-1:0] trim;
    logic               rd_hit;
    logic [`DATA_W-1:0] rd_val;
    logic               trim_wr;

    modport host (output addr, wdata, wr, sys_reset, flash_trim,
                  input  trim, rd_hit, rd_val, trim_wr);
    modport regs (input  addr, wdata, wr, sys_reset, flash_trim,
                  output trim, rd_hit, rd_val, trim_wr);
endinterface : trim_if

// ### verilog/pin_sync.sv
// Two-stage synchroniser for inputs from outside the clock domain
`timescale 1ns/1ps
`include "rst_seq_cfg.svh"
module pin_sync
    import rst_seq_pkg::*;
(
    input  wire logic              clk_in,     // System clock
    input  wire logic              rst_n_in,   // Async reset, active low
    input  wire logic [`SYNC_W-1:0] async_in,  // Raw inputs
    output logic      [`SYNC_W-1:0] sync_out   // Synchronised inputs
);
    sync_state_t st;
    sync_state_t next_st;

    always_comb begin
        next_st        = st;
        next_st.meta   = async_in;
        next_st.stable = st.meta;
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st <= '{meta: `SYNC_IDLE, stable: `SYNC_IDLE};
        end else begin
            st <= next_st;
        end
    end

    assign sync_out = st.stable;
endmodule : pin_sync

// ### verilog/ref_trim_regs.sv
// Reference clock trim registers and the two factory test registers
`timescale 1ns/1ps
`include "rst_seq_cfg.svh"
module ref_trim_regs
    import rst_seq_pkg::*;
(
    input  wire logic clk_in,    // System clock
    input  wire logic rst_n_in,  // Async reset, active low
    trim_if.regs      tb         // Register access and trim value
);
    trim_state_t st;
    trim_state_t next_st;

    always_comb begin
        next_st             = st;
        next_st.sys_reset_q = tb.sys_reset;
        if (st.sys_reset_q && !tb.sys_reset) begin
            next_st.trim = tb.flash_trim;
        end else if (tb.wr && tb.addr == `OFS_TRIM_HI) begin
            next_st.trim[`TRIM_W-1] = tb.wdata[`BIT_TRIM_TOP];
        end else if (tb.wr && tb.addr == `OFS_TRIM_LO) begin
            next_st.trim[`TRIM_W-2:0] = tb.wdata;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st <= '{trim: `RST_TRIM, sys_reset_q: 1'b1};
        end else begin
            st <= next_st;
        end
    end

    // Lower value speeds the reference, higher slows it; bits binary weighted
    assign tb.trim    = st.trim;
    assign tb.trim_wr = tb.wr && (tb.addr == `OFS_TRIM_HI || tb.addr == `OFS_TRIM_LO);

    // Test registers ignore writes; only reads are decoded here
    always_comb begin
        tb.rd_hit = 1'b1;
        unique case (tb.addr)
            `OFS_TRIM_HI:   tb.rd_val = {7'h00, st.trim[`TRIM_W-1]};
            `OFS_TRIM_LO:   tb.rd_val = st.trim[`TRIM_W-2:0];
            `OFS_TEST_ZERO: tb.rd_val = `RST_BYTE;
            `OFS_TEST_ONE:  tb.rd_val = `TEST_ONE_VALUE;
            default: begin
                tb.rd_hit = 1'b0;
                tb.rd_val = `RST_BYTE;
            end
        endcase
    end
endmodule : ref_trim_regs

// ### verilog/reset_sequencer_and_ref_trim.sv
// Reset sequencer, lock status flags and reference trim register top
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`include "rst_seq_cfg.svh"
module reset_sequencer_and_ref_trim
    import rst_seq_pkg::*;
(
    input  wire logic               CLK_IN,              // Oscillator clock, 125 MHz
    input  wire logic               RST_N_IN,            // Power-on detect, active low
    input  wire logic               RESET_PIN_IN,        // Reset pin level
    output logic                    RESET_PIN_OUT,       // Reset pin drive value
    output logic                    RESET_PIN_OE_OUT,    // Reset pin drive enable
    input  wire logic               ILLEGAL_ACCESS_IN,   // Illegal address access pulse
    input  wire logic               WATCHDOG_TIMEOUT_IN, // Watchdog timeout pulse
    input  wire logic               OSC_FAIL_IN,         // Oscillator monitor failure
    input  wire logic               FREQ_LOCK_IN,        // Loop lock condition
    input  wire logic               STOP_ENTRY_IN,       // Stop mode entry pulse
    input  wire logic               LOOP_CFG_WRITE_IN,   // Multiplier register written
    input  wire logic [`TRIM_W-1:0] FLASH_TRIM_IN,       // Factory trim from flash
    input  wire logic [`ADDR_W-1:0] ADDR_IN,             // Register address
    input  wire logic [`DATA_W-1:0] WDATA_IN,            // Register write data
    input  wire logic               WR_IN,               // Write strobe
    input  wire logic               RD_IN,               // Read strobe
    output logic      [`DATA_W-1:0] RDATA_OUT,           // Read data, one cycle later
    output logic      [`TRIM_W-1:0] TRIM_OUT,            // Reference clock trim
    output logic                    INTERNAL_RESET_OUT,  // System reset, active high
    output logic      [1:0]         VECTOR_OUT,          // Selected reset vector
    output logic                    LOCK_IRQ_OUT         // Lock change interrupt request
);
    top_state_t         st;
    top_state_t         next_st;
    logic [`SYNC_W-1:0] sync_q;
    logic               pin_s;
    logic               osc_fail_s;
    logic               osc_fail_eff;
    logic               int_evt;
    logic               lock_clear;
    logic [`DATA_W-1:0] read_val;
    logic [`DATA_W-1:0] flags_val;

    trim_if tb ();

    //------------------------------------------------------------------
    // Helpers
    //------------------------------------------------------------------
    function automatic logic wr_hit(input logic [`ADDR_W-1:0] ofs);
        return WR_IN && ADDR_IN == ofs;
    endfunction : wr_hit

    function automatic logic clr_hit(input logic [`ADDR_W-1:0] ofs, input int pos);
        return WR_IN && ADDR_IN == ofs && WDATA_IN[pos];
    endfunction : clr_hit

    //------------------------------------------------------------------
    // Input synchronisers and trim registers
    //------------------------------------------------------------------
    pin_sync u_sync (
        .clk_in   (CLK_IN),
        .rst_n_in (RST_N_IN),
        .async_in ({OSC_FAIL_IN, RESET_PIN_IN}),
        .sync_out (sync_q)
    );

    assign pin_s      = sync_q[0];
    assign osc_fail_s = sync_q[1];

    assign tb.addr       = ADDR_IN;
    assign tb.wdata      = WDATA_IN;
    assign tb.wr         = WR_IN;
    assign tb.sys_reset  = INTERNAL_RESET_OUT;
    assign tb.flash_trim = FLASH_TRIM_IN;

    ref_trim_regs u_trim (
        .clk_in   (CLK_IN),
        .rst_n_in (RST_N_IN),
        .tb       (tb.regs)
    );

    //------------------------------------------------------------------
    // Event decode
    //------------------------------------------------------------------
    assign osc_fail_eff = osc_fail_s && st.osc_enable;
    assign int_evt      = ILLEGAL_ACCESS_IN || WATCHDOG_TIMEOUT_IN || osc_fail_eff;
    assign lock_clear   = STOP_ENTRY_IN || LOOP_CFG_WRITE_IN || (WR_IN && ADDR_IN == `OFS_CTRL)
                          || tb.trim_wr;

    always_comb begin
        flags_val                = `RST_BYTE;
        flags_val[`BIT_POR]      = st.power_on_flag;
        flags_val[`BIT_LOCK_IF]  = st.lock_change_flag;
        flags_val[`BIT_LOCK_ST]  = st.freq_lock_status;
        flags_val[`BIT_ILLEGAL]  = st.illegal_access_flag;
    end

    always_comb begin
        unique case (ADDR_IN)
            `OFS_CTRL: begin
                read_val              = `RST_BYTE;
                read_val[`BIT_LOCK_IE] = st.lock_irq_enable;
                read_val[`BIT_OSC_EN]  = st.osc_enable;
            end
            `OFS_FLAGS: read_val = flags_val;
            default:    read_val = tb.rd_hit ? tb.rd_val : `RST_BYTE;
        endcase
    end

    //------------------------------------------------------------------
    // Next state
    //------------------------------------------------------------------
    always_comb begin
        next_st       = st;
        next_st.rdata = RD_IN ? read_val : `RST_BYTE;

        // Sequencer
        unique case (st.state)
            S_IDLE: begin
                if (int_evt || !pin_s) begin
                    next_st.state = S_DRIVE;
                    next_st.cnt   = `RST_CNT;
                end
            end
            S_DRIVE: begin
                if (int_evt) begin
                    next_st.cnt = `RST_CNT;
                end else if (st.cnt == `DRIVE_CYCLES - `CNT_STEP) begin
                    next_st.state = S_WAIT;
                    next_st.cnt   = `RST_CNT;
                end else begin
                    next_st.cnt = st.cnt + `CNT_STEP;
                end
            end
            S_WAIT: begin
                if (int_evt) begin
                    next_st.state = S_DRIVE;
                    next_st.cnt   = `RST_CNT;
                end else if (st.cnt == `SAMPLE_WAIT - `CNT_STEP) begin
                    next_st.cnt = `RST_CNT;
                    if (!pin_s) begin
                        next_st.vector = VEC_POR;
                        next_st.state  = S_HOLD;
                    end else begin
                        next_st.state  = S_IDLE;
                        next_st.vector = st.osc_pend  ? VEC_OSC  :
                                         st.wdog_pend ? VEC_WDOG : VEC_POR;
                    end
                end else begin
                    next_st.cnt = st.cnt + `CNT_STEP;
                end
            end
            S_HOLD: begin
                if (int_evt) begin
                    next_st.state = S_DRIVE;
                    next_st.cnt   = `RST_CNT;
                end else if (pin_s) begin
                    next_st.state = S_IDLE;
                end
            end
            default: begin
                next_st.state = S_DRIVE;
                next_st.cnt   = `RST_CNT;
            end
        endcase

        // Pending causes recorded for vector choice, dropped once out of reset
        if (next_st.state == S_IDLE) begin
            next_st.osc_pend  = 1'b0;
            next_st.wdog_pend = 1'b0;
        end else begin
            next_st.osc_pend  = st.osc_pend  || osc_fail_eff;
            next_st.wdog_pend = st.wdog_pend || WATCHDOG_TIMEOUT_IN;
        end

        // Control register
        if (wr_hit(`OFS_CTRL)) begin
            next_st.lock_irq_enable = WDATA_IN[`BIT_LOCK_IE];
            next_st.osc_enable      = WDATA_IN[`BIT_OSC_EN];
        end

        // Lock status and change flag; flag set wins over its write clear, lock_clear wins over a lock change
        next_st.lock_change_flag = st.lock_change_flag
                                   && !clr_hit(`OFS_FLAGS, `BIT_LOCK_IF);
        if (lock_clear) begin
            next_st.freq_lock_status = 1'b0;
        end else if (FREQ_LOCK_IN != st.freq_lock_status) begin
            next_st.freq_lock_status = FREQ_LOCK_IN;
            next_st.lock_change_flag = 1'b1;
        end

        // Sticky flags
        next_st.power_on_flag = st.power_on_flag
                                && !clr_hit(`OFS_FLAGS, `BIT_POR);
        next_st.illegal_access_flag = ILLEGAL_ACCESS_IN
                                      || (st.illegal_access_flag
                                          && !clr_hit(`OFS_FLAGS, `BIT_ILLEGAL));
    end

    //------------------------------------------------------------------
    // State register; power-on enters the drive phase at once
    //------------------------------------------------------------------
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            st <= '{state: S_DRIVE, cnt: `RST_CNT, osc_pend: 1'b0, wdog_pend: 1'b0,
                    vector: VEC_POR, lock_irq_enable: 1'b0, osc_enable: 1'b0,
                    freq_lock_status: 1'b0, lock_change_flag: 1'b0,
                    power_on_flag: 1'b1, illegal_access_flag: 1'b0,
                    rdata: `RST_BYTE};
        end else begin
            st <= next_st;
        end
    end

    //------------------------------------------------------------------
    // Outputs
    //------------------------------------------------------------------
    assign RESET_PIN_OUT      = 1'b0;
    assign RESET_PIN_OE_OUT   = st.state == S_DRIVE;
    assign INTERNAL_RESET_OUT = st.state != S_IDLE;
    assign VECTOR_OUT         = st.vector;
    assign RDATA_OUT          = st.rdata;
    assign TRIM_OUT           = tb.trim;
    assign LOCK_IRQ_OUT       = st.lock_change_flag && st.lock_irq_enable;

    //------------------------------------------------------------------
    // Checks
    //------------------------------------------------------------------
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RST_N_IN);

    AST_DRIVE_END: assert property ($fell(RESET_PIN_OE_OUT) && st.state == S_WAIT
        |-> $past(st.cnt) == `DRIVE_CYCLES - `CNT_STEP)
        else $error("Drive phase length wrong");
    AST_WAIT_END: assert property (st.state == S_WAIT && !int_evt
        && st.cnt == `SAMPLE_WAIT - `CNT_STEP
        |=> st.state == S_IDLE || st.state == S_HOLD) else $error("Sample not taken");
    AST_HOLD_PIN: assert property (st.state == S_HOLD && !pin_s
        |=> INTERNAL_RESET_OUT ##1 INTERNAL_RESET_OUT || pin_s)
        else $error("Reset dropped while pin low");
    AST_HOLD_EXIT: assert property (st.state == S_HOLD && pin_s && !int_evt
        |=> !INTERNAL_RESET_OUT) else $error("Reset kept after pin release");
    AST_RESTART: assert property (st.state != S_IDLE && int_evt
        |=> st.state == S_DRIVE && st.cnt == `RST_CNT && RESET_PIN_OE_OUT)
        else $error("Event did not restart drive");
    AST_ENTRY: assert property (st.state == S_IDLE && (int_evt || !pin_s)
        |=> RESET_PIN_OE_OUT && INTERNAL_RESET_OUT) else $error("Reset event not taken");
    AST_VEC_OSC: assert property (st.state == S_WAIT && !int_evt && pin_s
        && st.osc_pend && st.cnt == `SAMPLE_WAIT - `CNT_STEP
        |=> VECTOR_OUT == VEC_OSC && !INTERNAL_RESET_OUT)
        else $error("Oscillator vector not chosen");
    AST_VEC_WDOG: assert property (st.state == S_WAIT && !int_evt && pin_s
        && !st.osc_pend && st.wdog_pend && st.cnt == `SAMPLE_WAIT - `CNT_STEP
        |=> VECTOR_OUT == VEC_WDOG) else $error("Watchdog vector not chosen");
    AST_TRIM_CLR: assert property (tb.trim_wr
        |=> !st.freq_lock_status && $stable(st.lock_change_flag))
        else $error("Trim write lock effect");
    AST_STOP_CLR: assert property (STOP_ENTRY_IN || LOOP_CFG_WRITE_IN
        |=> !st.freq_lock_status) else $error("Lock status kept after stop");
    AST_LOCK_FLAG: assert property (!lock_clear
        && FREQ_LOCK_IN != st.freq_lock_status
        |=> st.lock_change_flag ##0 LOCK_IRQ_OUT == st.lock_irq_enable)
        else $error("Lock change not flagged");
    AST_FLAG_CLR: assert property (WR_IN && ADDR_IN == `OFS_FLAGS
        && WDATA_IN[`BIT_LOCK_IF] && (lock_clear || FREQ_LOCK_IN == st.freq_lock_status)
        |=> !st.lock_change_flag && !LOCK_IRQ_OUT) else $error("Lock flag not cleared");
    AST_POR_STICKY: assert property (st.power_on_flag
        && !(WR_IN && ADDR_IN == `OFS_FLAGS && WDATA_IN[`BIT_POR])
        |=> st.power_on_flag) else $error("Power-on flag lost");
    AST_ILL_SET: assert property (ILLEGAL_ACCESS_IN
        |=> st.illegal_access_flag && INTERNAL_RESET_OUT)
        else $error("Illegal access not recorded");
    AST_ILL_CLR: assert property (WR_IN && ADDR_IN == `OFS_FLAGS
        && WDATA_IN[`BIT_ILLEGAL] && !ILLEGAL_ACCESS_IN
        |=> !st.illegal_access_flag) else $error("Illegal flag not cleared");
    AST_TEST_ZERO: assert property (RD_IN && ADDR_IN == `OFS_TEST_ZERO
        |=> RDATA_OUT == `RST_BYTE) else $error("Test register not zero");
    AST_TRIM_HI_RD: assert property (RD_IN && ADDR_IN == `OFS_TRIM_HI
        |=> RDATA_OUT[`DATA_W-1:1] == 7'h00) else $error("Trim high upper bits set");
    AST_TRIM_LOAD: assert property ($fell(INTERNAL_RESET_OUT)
        |=> TRIM_OUT == $past(FLASH_TRIM_IN)) else $error("Flash trim not loaded");
    AST_OSC_GATE: assert property (st.state == S_IDLE && !st.osc_enable && pin_s
        && !ILLEGAL_ACCESS_IN && !WATCHDOG_TIMEOUT_IN |=> !INTERNAL_RESET_OUT)
        else $error("Gated oscillator fail caused reset");

    COV_RESTART:  cover property (st.state == S_WAIT && int_evt);
    COV_HOLD:     cover property (st.state == S_HOLD ##1 st.state == S_IDLE);
    COV_VEC_WDOG: cover property (VECTOR_OUT == VEC_WDOG && !INTERNAL_RESET_OUT);
    COV_VEC_OSC:  cover property (VECTOR_OUT == VEC_OSC && !INTERNAL_RESET_OUT);
    COV_LOCK_IRQ: cover property ($rose(LOCK_IRQ_OUT));
endmodule : reset_sequencer_and_ref_trim
